// ### shared/spfpi_pkg.sv
// constants and types for the spi supervision block
package spfpi_pkg;
	localparam int WORD_W_DEF   = 8;
	localparam int DIV_W        = 8;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam int FIFO_DEPTH   = 8;
	localparam logic [15:0] DATA_RST = 16'h0000;
	typedef enum logic [1:0] {
		SPFPI_IDLE = 2'b00,
		SPFPI_LEAD = 2'b01,
		SPFPI_XFER = 2'b11,
		SPFPI_TAIL = 2'b10
	} spfpi_state_e;
endpackage : spfpi_pkg

// ### verilog/spfpi_core.sv
// spi master/slave with mode fault, single-wire, low power and irq logic
module spfpi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_flush,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic      [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;
	assign o_valid = wr_q != rd_q;
	assign o_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem[rd_q[AW-1:0]];
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (i_flush) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (push)
			mem[wr_q[AW-1:0]] <= i_data;
	end
endmodule : spfpi_fifo

// Functional notes
// - slave-select output low during each transfer, high while idle
// - select output only as master with output and fault enables set
// - no mode-fault detection while select output is enabled
// - single-wire: master uses mosi pin, slave uses miso pin
// - drive enable sets shared pin direction; pin always feeds shifter
// - sck out as master, in as slave; select input as slave
// - single-wire master fault moves device to slave on miso
// - select low as master with fault detection sets fault flag
// - no fault when detection disabled or as slave
// - fault clears master, tristates pins, aborts transfer to idle
// - fault in single-wire master drops data pin output enable
// - fault flag clears on status read then control one write
// - pending receive word lost on mode fault
// - system enable clear disables core, registers stay accessible
// - halt in wait stops master transfer, resumes on exit
// - halted slave keeps shifting on the external sck while in wait
// - low power slave defers receive flag and copy until exit
// - stop freezes master and keeps slave in step
// - data reads zero after reset
// - irq is or of three flags, only while enabled
// - receive flag set on copy to data register, sticky
// - transmit empty set when the tx fifo has room and no data write is strobed
// - receive flag set half sck period after last edge as master, on the last edge as slave
// - baud divider runs only as master during transfer
module spfpi_core
	import spfpi_pkg::*;
#(
	parameter int WORD_W = spfpi_pkg::WORD_W_DEF
) (
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	// configuration
	input  wire logic              i_system_enable,
	input  wire logic              i_controller_select_set,
	input  wire logic              i_select_output_enable,
	input  wire logic              i_fault_detect_enable,
	input  wire logic              i_single_wire_select,
	input  wire logic              i_single_wire_drive_enable,
	input  wire logic              i_halt_in_wait,
	input  wire logic [spfpi_pkg::DIV_W-1:0] i_half_div,
	// power state
	input  wire logic              i_wait_mode,
	input  wire logic              i_stop_mode,
	// software access strobes
	input  wire logic              i_status_read,
	input  wire logic              i_ctrl_one_write,
	input  wire logic              i_data_read,
	input  wire logic              i_data_write,
	input  wire logic [WORD_W-1:0] i_data_wr,
	// register view
	output logic                   o_controller_select,
	output logic                   o_fault_flag,
	output logic                   o_receive_full_flag,
	output logic                   o_transmit_empty_flag,
	output logic      [WORD_W-1:0] o_data_register,
	output logic                   o_irq,
	output logic                   o_busy,
	// spi pins
	output logic                   o_sck,
	output logic                   o_sck_oe,
	input  wire logic              i_sck,
	input  wire logic              i_ss_n,
	output logic                   o_ss_n,
	output logic                   o_ss_oe,
	input  wire logic              i_mosi,
	output logic                   o_mosi,
	output logic                   o_mosi_oe,
	input  wire logic              i_miso,
	output logic                   o_miso,
	output logic                   o_miso_oe
);
	localparam int BW = $clog2(WORD_W + 1);
	if (WORD_W != 8 && WORD_W != 16) begin : g_bad_width
		$error("word width must be 8 or 16");
	end

	typedef struct packed {
		spfpi_state_e            st;
		logic                    controller_select;
		logic                    fault_flag;
		logic                    receive_full_flag;
		logic                    transmit_empty_flag;
		logic                    sr_seen_fault_flag;
		logic                    sr_seen_receive_full_flag;
		logic                    sr_seen_transmit_empty_flag;
		logic [WORD_W-1:0]       dr;
		logic [WORD_W-1:0]       sh;
		logic [BW-1:0]           bits;
		logic [DIV_W-1:0]        div;
		logic                    sck;
		logic                    sck_in;
		logic                    ss_in;
		logic                    pend;
		logic                    lp_mid;
	} spfpi_s;

	spfpi_s s_q, s_d;
	logic              fifo_valid;
	logic [WORD_W-1:0] fifo_data;
	logic              fifo_pop;
	logic              fifo_ready;
	logic              txin_ready;

	// halt master clocking in wait (when asked) or stop
	logic low_power;
	logic halt_m;
	logic ser_in;
	logic ssout_on;
	logic fault_ev;
	logic s_rise;
	logic s_fall;
	logic s_sel;
	assign low_power = i_stop_mode || (i_wait_mode && i_halt_in_wait);
	assign halt_m    = !i_system_enable || low_power;
	assign ssout_on  = s_q.controller_select && i_select_output_enable
		&& i_fault_detect_enable;
	assign fault_ev  = i_system_enable && s_q.controller_select && i_fault_detect_enable
		&& !i_select_output_enable && !i_ss_n;
	// single-wire: master reads mosi, slave reads miso
	assign ser_in = i_single_wire_select
		? (s_q.controller_select ? i_mosi : i_miso)
		: (s_q.controller_select ? i_miso : i_mosi);
	assign s_sel  = !i_ss_n && !s_q.controller_select && i_system_enable;
	assign s_rise = s_sel && i_sck && !s_q.sck_in;
	assign s_fall = s_sel && !i_sck && s_q.sck_in;
	assign fifo_pop = (s_q.st == SPFPI_IDLE) && s_q.controller_select && !halt_m
		&& !s_q.fault_flag;

	spfpi_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_txq (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_flush   (fault_ev),
		.i_valid   (i_data_write),
		.o_ready   (fifo_ready),
		.i_data    (i_data_wr),
		.o_valid   (fifo_valid),
		.i_ready   (fifo_pop),
		.o_data    (fifo_data)
	);
	assign txin_ready = fifo_ready;

	always_comb begin
		s_d = s_q;
		s_d.sck_in = i_sck;
		s_d.ss_in  = i_ss_n;
		if (i_ctrl_one_write)
			s_d.controller_select = i_controller_select_set;
		if (i_status_read) begin
			s_d.sr_seen_fault_flag  = s_q.fault_flag;
			s_d.sr_seen_receive_full_flag  = s_q.receive_full_flag;
			s_d.sr_seen_transmit_empty_flag = s_q.transmit_empty_flag;
		end
		if (i_ctrl_one_write && s_q.sr_seen_fault_flag) begin
			s_d.fault_flag = 1'b0;
			s_d.sr_seen_fault_flag = 1'b0;
		end
		if (i_data_read && s_q.sr_seen_receive_full_flag) begin
			s_d.receive_full_flag = 1'b0;
			s_d.sr_seen_receive_full_flag = 1'b0;
		end
		if (i_data_write && s_q.sr_seen_transmit_empty_flag) begin
			s_d.transmit_empty_flag = 1'b0;
			s_d.sr_seen_transmit_empty_flag = 1'b0;
		end
		if (!i_data_write && txin_ready && !s_q.transmit_empty_flag)
			s_d.transmit_empty_flag = 1'b1;
		if (!low_power && s_q.lp_mid) begin
			s_d.lp_mid = 1'b0;
			s_d.dr     = s_q.sh;
			s_d.receive_full_flag   = 1'b1;
		end
		if (fault_ev) begin
			s_d.fault_flag = 1'b1;
			s_d.controller_select = 1'b0;
			s_d.st   = SPFPI_IDLE;
			s_d.bits = '0;
			s_d.sck  = 1'b0;
			s_d.div  = '0;
			s_d.pend = 1'b0;
		end else if (s_q.controller_select) begin
			unique case (s_q.st)
				SPFPI_IDLE: begin
					s_d.div = '0;
					if (fifo_pop && fifo_valid) begin
						s_d.sh   = fifo_data;
						s_d.st   = SPFPI_LEAD;
						s_d.bits = BW'(WORD_W);
					end
				end
				SPFPI_LEAD, SPFPI_XFER, SPFPI_TAIL: begin
					if (!halt_m) begin
						if (s_q.div >= i_half_div) begin
							s_d.div = '0;
							unique case (s_q.st)
								SPFPI_LEAD: s_d.st = SPFPI_XFER;
								SPFPI_XFER: begin
									s_d.sck = !s_q.sck;
									if (!s_q.sck) begin
										s_d.pend = ser_in;
									end else begin
										s_d.sh   = {s_q.sh[WORD_W-2:0],
											s_q.pend};
										s_d.bits = s_q.bits - 1'b1;
										if (s_q.bits == BW'(1))
											s_d.st = SPFPI_TAIL;
									end
								end
								default: begin
									s_d.dr   = s_q.sh;
									s_d.receive_full_flag = 1'b1;
									s_d.st   = SPFPI_IDLE;
								end
							endcase
						end else begin
							s_d.div = s_q.div + 1'b1;
						end
					end
				end
			endcase
		end else begin
			// slave: shifter follows external sck even in low power
			s_d.st  = SPFPI_IDLE;
			s_d.div = '0;
			if (i_system_enable && s_q.ss_in && i_ss_n == 1'b0) begin
				s_d.bits = BW'(WORD_W);
				if (!low_power)
					s_d.sh = s_q.dr;
			end
			if (s_rise) begin
				s_d.pend = ser_in;
			end
			if (s_fall && s_q.bits != '0) begin
				s_d.sh   = {s_q.sh[WORD_W-2:0], s_q.pend};
				s_d.bits = s_q.bits - 1'b1;
				if (s_q.bits == BW'(1)) begin
					if (low_power)
						s_d.lp_mid = 1'b1;
					else begin
						s_d.dr   = {s_q.sh[WORD_W-2:0], s_q.pend};
						s_d.receive_full_flag = 1'b1;
					end
					s_d.bits = BW'(WORD_W);
				end
			end
			if (low_power && !i_wait_mode && !i_stop_mode)
				s_d.lp_mid = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '{st: SPFPI_IDLE, div: '0, bits: '0,
				dr: WORD_W'(DATA_RST), sh: '0, sck_in: 1'b0,
				ss_in: 1'b1, transmit_empty_flag: 1'b1, default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign o_controller_select   = s_q.controller_select;
	assign o_fault_flag          = s_q.fault_flag;
	assign o_receive_full_flag   = s_q.receive_full_flag;
	assign o_transmit_empty_flag = s_q.transmit_empty_flag;
	assign o_data_register       = s_q.dr;
	assign o_busy                = s_q.st != SPFPI_IDLE;
	assign o_irq = i_system_enable
		&& (s_q.fault_flag || s_q.receive_full_flag || s_q.transmit_empty_flag);
	assign o_sck     = s_q.sck;
	assign o_sck_oe  = s_q.controller_select && i_system_enable;
	assign o_ss_n    = !o_busy;
	assign o_ss_oe   = ssout_on && i_system_enable;
	assign o_mosi    = s_q.sh[WORD_W-1];
	assign o_miso    = s_q.sh[WORD_W-1];
	// after a fault controller_select is low so master pins are released
	assign o_mosi_oe = i_system_enable && s_q.controller_select && !s_q.fault_flag
		&& (!i_single_wire_select || i_single_wire_drive_enable);
	assign o_miso_oe = i_system_enable && !s_q.controller_select && !s_q.fault_flag && s_sel
		&& (!i_single_wire_select || i_single_wire_drive_enable);

	a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_irq |-> i_system_enable && (s_q.fault_flag || s_q.receive_full_flag || s_q.transmit_empty_flag))
		else $error("irq without enabled flag");
	a_fault_set: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		fault_ev |=> o_fault_flag && !o_controller_select && !o_busy)
		else $error("fault not taken");
	a_no_slave_fault: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		!s_q.controller_select && !s_q.fault_flag |=> !s_q.fault_flag)
		else $error("fault raised as slave");
	a_ss_output: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_ss_oe |-> s_q.controller_select && i_fault_detect_enable)
		else $error("select output outside master");
	a_div_idle: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!s_q.controller_select || s_q.st == SPFPI_IDLE |=> s_q.div == '0)
		else $error("divider running idle");
	a_halt_freeze: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		halt_m && s_q.controller_select && !fault_ev |=> $stable(s_q.sh) && $stable(s_q.sck))
		else $error("master moved while halted");
	a_fault_flag_clear: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		s_q.fault_flag && !s_q.sr_seen_fault_flag && !fault_ev |=> s_q.fault_flag)
		else $error("fault flag cleared early");
	a_lp_defer: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!s_q.controller_select && low_power && !s_q.receive_full_flag && !i_data_read |=> !s_q.receive_full_flag)
		else $error("receive flag during low power");
endmodule : spfpi_core

// ### verification/spfpi_slave_model.sv
// behavioural spi slave seen by the block in master mode
module spfpi_slave_model (
	// spi pins
	input  wire logic       i_sck,
	input  wire logic       i_ss_n,
	input  wire logic       i_mosi,
	output logic            o_miso,
	// test side
	input  wire logic [7:0] i_tx,
	output logic      [7:0] o_rx
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;
	logic       last;
	initial begin
		sh = 8'h00;
		last = 1'b0;
		o_rx = 8'h00;
	end
	// mode 0: load on select, sample rising, shift falling
	always @(negedge i_ss_n) sh = i_tx;
	always @(posedge i_sck) if (!i_ss_n) o_rx = {o_rx[6:0], i_mosi};
	always @(negedge i_sck) if (!i_ss_n) sh = {sh[6:0], 1'b0};
	always @(posedge i_ss_n) last = sh[7];
	// released line shows the inverse of the last bit
	assign o_miso = i_ss_n ? ~last : sh[7];
endmodule // spfpi_slave_model

// ### verification/tb_top.sv
// self-checking bench for the spi supervision block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spfpi_pkg::*;
	logic       clk, rst_n, en, mst, sso, fde, sws, swd, hiw, wm, sm;
	logic [3:0] stb;
	logic [7:0] wr, dreg, stx, srx;
	logic       tb_ss_n, cs, ff, rf, tf, irq, busy, sck, sck_oe;
	logic       tb_sck, tb_mosi;
	logic       ss_n, ss_oe, mosi, mosi_oe, miso, miso_oe, m_miso;
	int         error_cnt, checks, cyc;
	wire        ss_w   = ss_oe ? ss_n : tb_ss_n;
	wire        sck_w  = sck_oe ? sck : tb_sck;
	wire        mosi_w = mosi_oe ? mosi : tb_mosi;
	wire        miso_w = miso_oe ? miso : m_miso;

	spfpi_core #(.WORD_W(8)) i_spfpi_core (
		.i_sys_clk(clk), .i_arst_n(rst_n), .i_system_enable(en),
		.i_controller_select_set(mst), .i_select_output_enable(sso),
		.i_fault_detect_enable(fde), .i_single_wire_select(sws),
		.i_single_wire_drive_enable(swd), .i_halt_in_wait(hiw),
		.i_half_div(8'h01), .i_wait_mode(wm), .i_stop_mode(sm),
		.i_status_read(stb[3]), .i_ctrl_one_write(stb[2]),
		.i_data_read(stb[1]), .i_data_write(stb[0]), .i_data_wr(wr),
		.o_controller_select(cs), .o_fault_flag(ff),
		.o_receive_full_flag(rf), .o_transmit_empty_flag(tf),
		.o_data_register(dreg), .o_irq(irq), .o_busy(busy),
		.o_sck(sck), .o_sck_oe(sck_oe), .i_sck(sck_w), .i_ss_n(ss_w),
		.o_ss_n(ss_n), .o_ss_oe(ss_oe), .i_mosi(mosi_w), .o_mosi(mosi),
		.o_mosi_oe(mosi_oe), .i_miso(miso_w), .o_miso(miso),
		.o_miso_oe(miso_oe));
	spfpi_slave_model i_spfpi_slave_model (.i_sck(sck_w), .i_ss_n(ss_w),
		.i_mosi(mosi_w), .o_miso(m_miso), .i_tx(stx), .o_rx(srx));

	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string what);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// {status read, ctrl write, data read, data write}
	task automatic strobe(input logic [3:0] s, input logic [7:0] d);
		stb = s;
		wr = d;
		tick(1);
		stb = 4'h0;
		tick(1);
	endtask
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 400) begin
			tick(1);
			n++;
		end
		chk(8'(busy), 8'(v), "busy");
	endtask
	task automatic rx_clear();
		strobe(4'h8, 8'h00);
		strobe(4'h2, 8'h00);
		chk(8'(rf), 8'h00, "rx clear");
	endtask

	task automatic t_reset();
		chk({ff, rf, tf, cs, sck_oe, mosi_oe, miso_oe, ss_oe}, 8'h20, "rst");
		chk(dreg, 8'h00, "data after reset");
		chk(8'(irq), 8'h00, "irq disabled");
		en = 1'b1;
		tick(1);
		chk(8'(irq), 8'h01, "irq tx empty");
	endtask
	task automatic t_master();
		sso = 1'b1;
		fde = 1'b1;
		stx = 8'h3c;
		mst = 1'b1;
		strobe(4'h4, 8'h00);
		chk(8'(cs), 8'h01, "master set");
		strobe(4'h1, 8'ha5);
		wait_busy(1'b1);
		chk({ff, ss_oe, ss_n, sck_oe, mosi_oe}, 8'h0b, "pins busy");
		wait_busy(1'b0);
		tick(1);
		chk({rf, ss_n, irq}, 8'h07, "done");
		chk(dreg, 8'h3c, "rx word");
		chk(srx, 8'ha5, "tx word");
		strobe(4'h2, 8'h00);
		chk(8'(rf), 8'h01, "read alone");
		rx_clear();
	endtask
	task automatic t_fault_off();
		sso = 1'b0;
		fde = 1'b0;
		tb_ss_n = 1'b0;
		tick(4);
		chk({ff, cs}, 8'h01, "no fault");
		tb_ss_n = 1'b1;
		tick(1);
	endtask
	task automatic t_fault(input logic sw);
		sws = sw;
		swd = sw;
		fde = 1'b1;
		strobe(4'h1, 8'h5a);
		wait_busy(1'b1);
		tick(4);
		tb_ss_n = 1'b0;
		tick(2);
		chk({ff, cs, busy, rf, sck_oe, mosi_oe, miso_oe}, 8'h40, "fault");
		tb_ss_n = 1'b1;
		strobe(4'h4, 8'h00);
		chk(8'(ff), 8'h01, "write alone");
		strobe(4'h8, 8'h00);
		strobe(4'h4, 8'h00);
		chk({ff, cs}, 8'h01, "fault clear");
		sws = 1'b0;
		swd = 1'b0;
	endtask
	task automatic t_single();
		sws = 1'b1;
		swd = 1'b1;
		sso = 1'b1;
		strobe(4'h1, 8'hc6);
		wait_busy(1'b1);
		chk({mosi_oe, miso_oe}, 8'h02, "single pins");
		wait_busy(1'b0);
		tick(1);
		chk(dreg, 8'hc6, "loopback");
		rx_clear();
		sso = 1'b0;
	endtask
	task automatic t_freeze(input logic stp);
		logic s0;
		sso = 1'b1;
		hiw = 1'b1;
		stx = 8'he7;
		strobe(4'h1, 8'h81);
		wait_busy(1'b1);
		tick(6);
		wm = ~stp;
		sm = stp;
		tick(1);
		s0 = sck;
		tick(12);
		chk({busy, sck}, {6'h00, 1'b1, s0}, "frozen");
		wm = 1'b0;
		sm = 1'b0;
		wait_busy(1'b0);
		tick(1);
		chk(dreg, 8'he7, "resumed rx");
		chk(srx, 8'h81, "resumed tx");
		rx_clear();
	endtask
	task automatic t_fifo();
		wm = 1'b1;
		for (int i = 0; i < 8; i++)
			strobe(4'h1, 8'(i));
		strobe(4'h8, 8'h00);
		strobe(4'h1, 8'h08);
		chk(8'(tf), 8'h00, "fifo full");
		wm = 1'b0;
		tick(340);
		chk({busy, tf}, 8'h01, "drained");
		chk(srx, 8'h07, "ninth dropped");
		en = 1'b0;
		tick(1);
		chk(8'(irq), 8'h00, "irq gated");
		chk(dreg, 8'he7, "data kept");
	endtask
	// bench plays the external master, mode 0, msb first
	task automatic slave_xfer(input logic [7:0] b, output logic [7:0] got);
		got = 8'h00;
		tb_ss_n = 1'b0;
		tick(2);
		chk(8'(miso_oe), 8'h01, "slave drives miso");
		for (int i = 7; i >= 0; i--) begin
			got = {got[6:0], miso_w};
			tb_mosi = b[i];
			tb_sck = 1'b1;
			tick(2);
			tb_sck = 1'b0;
			tick(2);
		end
		tick(1);
		tb_ss_n = 1'b1;
		tick(2);
	endtask
	task automatic t_slave();
		logic [7:0] got;
		en = 1'b1;
		mst = 1'b0;
		strobe(4'h4, 8'h00);
		chk(8'(sck_oe), 8'h00, "sck input as slave");
		slave_xfer(8'h69, got);
		chk(got, 8'he7, "slave sends last rx");
		chk({rf, ff}, 8'h02, "slave rx flag");
		chk(dreg, 8'h69, "slave rx word");
		rx_clear();
		wm = 1'b1;
		slave_xfer(8'h96, got);
		chk(got, 8'h69, "wait repeats rx");
		chk(8'(rf), 8'h00, "rx flag deferred");
		chk(dreg, 8'h69, "copy deferred");
		wm = 1'b0;
		tick(1);
		chk(dreg, 8'h96, "copy on exit");
		chk(8'(rf), 8'h01, "flag on exit");
		rx_clear();
	endtask

	initial begin
		{clk, rst_n, en, mst, sso, fde, sws, swd, hiw, wm, sm} = 11'h000;
		{stb, wr, stx, error_cnt, checks, cyc} = '0;
		tb_ss_n = 1'b1;
		{tb_sck, tb_mosi} = 2'b00;
		repeat (2) @(posedge clk);
		#5;
		rst_n = 1'b1;
		tick(1);
		t_reset();
		t_master();
		t_fault_off();
		t_fault(1'b0);
		t_single();
		t_fault(1'b1);
		t_freeze(1'b0);
		t_freeze(1'b1);
		t_fifo();
		t_slave();
		final_report();
	end
endmodule // tb_top
